// ===== logic/sspb_pkg.sv
package sspb_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  localparam logic [ADDR_W-1:0] CAP_OFS = 12'h28c;
  localparam logic [ADDR_W-1:0] DV_OFS = 12'h300;
  localparam logic [ADDR_W-1:0] STS_OFS = 12'h400;
  localparam logic [ADDR_W-1:0] CTL_OFS = 12'h404;
  localparam int WORD_LSB = 2;
  localparam int DV_COUNT = 8;
  localparam int DV_IDX_W = 3;
  localparam int DV_LSB = WORD_LSB + DV_IDX_W;

  localparam int SA_BIT = 0;
  localparam int GUNLOCK_BIT = 3;
  localparam int DVUNLOCK_BIT = 4;

  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int SPEC_LSB = 10;
  localparam int SPEC_W = 2;
  localparam int LOCK_LSB = 20;
  localparam int LOCK_W = 3;
  localparam int MARKER_LSB = 28;
  localparam int MARKER_W = 4;
  localparam int CLK_STRAP_W = 5;
  localparam int MERGE_W = 3;
  localparam int STRAP_W = MODE_W + CLK_STRAP_W + MERGE_W;
  localparam logic [DATA_W-1:0] STS_RESV_MASK = 32'h0f8f8018;

  localparam logic [MODE_W-1:0] MODE_NORMAL = 3'h0;
  localparam logic [MODE_W-1:0] MODE_EEPROM = 3'h1;
  localparam logic [SPEC_W-1:0] SPEC_REV11 = 2'h1;
  localparam logic [MARKER_W-1:0] MARKER_RST = 4'h0;
  localparam logic [DATA_W-1:0] DV_RST = 32'h00000000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== logic/sspb_regs.sv
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - system allocated flag, bit zero, resets zero
// - locked fields writable only with global unlock; data words need only data unlock
// - eight data words, writes need data unlock
// - data unlock at control bit four, locked
// - operating mode pins read at bits 2:0
// - clock, bus, halt straps latched at reset
// - three merge straps latched, bits 12 to 14
// - base spec mode field, lock protected
// - locked port state read at 22:20
// - marker field survives hot reset
module sspb_regs #(
  parameter logic [sspb_pkg::SPEC_W-1:0] SPEC_INIT = sspb_pkg::SPEC_REV11
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hot_reset,
  input wire logic [sspb_pkg::MODE_W-1:0] operating_mode_pins,
  input wire logic downstream_common_clock_strap,
  input wire logic upstream_common_clock_strap,
  input wire logic slow_mgmt_bus_strap,
  input wire logic refclk_mode_strap,
  input wire logic reset_halt_strap,
  input wire logic merge_ports_zero_one,
  input wire logic merge_ports_two_three,
  input wire logic merge_ports_four_five,
  input wire logic [sspb_pkg::LOCK_W-1:0] locked_port_state,
  input wire logic [sspb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [sspb_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [sspb_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sspb_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [sspb_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic system_allocated_flag,
  output logic [sspb_pkg::SPEC_W-1:0] base_spec_mode,
  output logic global_register_unlock,
  output logic data_value_unlock
);
  import sspb_pkg::*;

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [STRB_W-1:0] w_strb;
  logic [MARKER_W-1:0] marker;
  logic [DV_COUNT-1:0][DATA_W-1:0] budget_data_word;
  logic [STRAP_W-1:0] strap_pins;
  logic [STRAP_W-1:0] strap_held;

  // straps are sampled on every edge while fundamental reset is low
  assign strap_pins = {merge_ports_four_five, merge_ports_two_three, merge_ports_zero_one,
                       reset_halt_strap, refclk_mode_strap, slow_mgmt_bus_strap,
                       upstream_common_clock_strap, downstream_common_clock_strap,
                       operating_mode_pins};

  sspb_strap_capture #(
    .WIDTH(STRAP_W)
  ) u_strap (
    .aclk(aclk),
    .capture(!aresetn),
    .pins(strap_pins),
    .held(strap_held)
  );

  // write channel: address and data taken in either order, one write at a time
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  wire [DATA_W-1:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire wr_cap = aw_addr[ADDR_W-1:WORD_LSB] == CAP_OFS[ADDR_W-1:WORD_LSB];
  wire wr_sts = aw_addr[ADDR_W-1:WORD_LSB] == STS_OFS[ADDR_W-1:WORD_LSB];
  wire wr_ctl = aw_addr[ADDR_W-1:WORD_LSB] == CTL_OFS[ADDR_W-1:WORD_LSB];
  wire wr_dv = aw_addr[ADDR_W-1:DV_LSB] == DV_OFS[ADDR_W-1:DV_LSB];
  wire [DV_IDX_W-1:0] wr_idx = aw_addr[DV_LSB-1:WORD_LSB];
  wire wr_hit = wr_cap || wr_sts || wr_ctl || wr_dv;

  // readback words, reserved bits tied low
  wire [DATA_W-1:0] cap_word = {{(DATA_W-1){1'b0}}, system_allocated_flag};
  wire [DATA_W-1:0] sts_word = {marker, 5'h00, locked_port_state, 5'h00,
                                strap_held[STRAP_W-1 -: MERGE_W], base_spec_mode,
                                strap_held[MODE_W +: CLK_STRAP_W], 2'h0,
                                strap_held[MODE_W-1:0]};
  wire [DATA_W-1:0] ctl_word = (DATA_W'(data_value_unlock) << DVUNLOCK_BIT)
                             | (DATA_W'(global_register_unlock) << GUNLOCK_BIT);

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] cur,
                                              input logic [DATA_W-1:0] wd,
                                              input logic [DATA_W-1:0] m);
    merge = (cur & ~m) | (wd & m);
  endfunction

  wire [DATA_W-1:0] cap_new = merge(cap_word, w_data, wmask);
  wire [DATA_W-1:0] sts_new = merge(sts_word, w_data, wmask);
  wire [DATA_W-1:0] ctl_new = merge(ctl_word, w_data, wmask);
  wire [DATA_W-1:0] dv_new = merge(budget_data_word[wr_idx], w_data, wmask);

  wire cap_we = do_write && wr_cap && global_register_unlock;
  wire spec_we = do_write && wr_sts && global_register_unlock;
  wire marker_we = do_write && wr_sts;
  wire dvul_we = do_write && wr_ctl && global_register_unlock;
  wire dv_we = do_write && wr_dv && data_value_unlock;

  // hot reset clears the non-sticky flag and wins over a write in the same cycle
  wire next_sa = hot_reset ? 1'b0 : (cap_we ? cap_new[SA_BIT] : system_allocated_flag);
  wire [SPEC_W-1:0] next_spec = spec_we ? sts_new[SPEC_LSB +: SPEC_W] : base_spec_mode;
  wire [MARKER_W-1:0] next_marker = marker_we ? sts_new[MARKER_LSB +: MARKER_W] : marker;
  wire next_unlock = (do_write && wr_ctl) ? ctl_new[GUNLOCK_BIT] : global_register_unlock;
  wire next_dvul = dvul_we ? ctl_new[DVUNLOCK_BIT] : data_value_unlock;

  // read decode; locked data words stay readable, only writes are blocked
  wire rd_cap = s_axi_araddr[ADDR_W-1:WORD_LSB] == CAP_OFS[ADDR_W-1:WORD_LSB];
  wire rd_sts = s_axi_araddr[ADDR_W-1:WORD_LSB] == STS_OFS[ADDR_W-1:WORD_LSB];
  wire rd_ctl = s_axi_araddr[ADDR_W-1:WORD_LSB] == CTL_OFS[ADDR_W-1:WORD_LSB];
  wire rd_dv = s_axi_araddr[ADDR_W-1:DV_LSB] == DV_OFS[ADDR_W-1:DV_LSB];
  wire [DV_IDX_W-1:0] rd_idx = s_axi_araddr[DV_LSB-1:WORD_LSB];
  wire rd_hit = rd_cap || rd_sts || rd_ctl || rd_dv;
  wire [DATA_W-1:0] rd_word = rd_cap ? cap_word :
                              rd_sts ? sts_word :
                              rd_ctl ? ctl_word :
                              rd_dv ? budget_data_word[rd_idx] :
                              '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // marker and unlock bits only clear on fundamental reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      system_allocated_flag <= 1'b0;
      base_spec_mode <= SPEC_INIT;
      marker <= MARKER_RST;
      global_register_unlock <= 1'b0;
      data_value_unlock <= 1'b0;
    end
    else
    begin
      system_allocated_flag <= next_sa;
      base_spec_mode <= next_spec;
      marker <= next_marker;
      global_register_unlock <= next_unlock;
      data_value_unlock <= next_dvul;
    end
  end

  // data words are sticky; the reset value is arbitrary since it is undefined
  for (genvar i = 0; i < DV_COUNT; i++)
  begin : g_dv
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        budget_data_word[i] <= DV_RST;
      end
      else if (dv_we && wr_idx == DV_IDX_W'(i))
      begin
        budget_data_word[i] <= dv_new;
      end
    end
  end

  a_sa_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_cap && !global_register_unlock && !hot_reset)
    |=> system_allocated_flag == $past(system_allocated_flag))
    else $error("system allocated flag changed while locked");

  a_sa_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (cap_we && w_strb[0] && !hot_reset) |=> system_allocated_flag == $past(w_data[SA_BIT]))
    else $error("system allocated flag missed an unlocked write");

  a_dv_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    !data_value_unlock |=> $stable(budget_data_word))
    else $error("data word changed while data unlock clear");

  a_dv_read_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && rd_dv && !data_value_unlock)
    |=> s_axi_rvalid && s_axi_rdata == $past(budget_data_word[rd_idx]))
    else $error("locked data word did not read back its contents");

  a_dvul_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_ctl && !global_register_unlock) |=> $stable(data_value_unlock))
    else $error("data unlock changed while globally locked");

  a_spec_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    !global_register_unlock |=> $stable(base_spec_mode))
    else $error("base spec mode changed while locked");

  a_mode_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && rd_sts) |=> s_axi_rdata[MODE_LSB +: MODE_W] == strap_held[MODE_W-1:0])
    else $error("operating mode field mismatch");

  a_lock_state: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && rd_sts) |=> s_axi_rdata[LOCK_LSB +: LOCK_W] == $past(locked_port_state))
    else $error("locked port state not reported");

  a_marker_hot: assert property (@(posedge aclk) disable iff (!aresetn)
    (hot_reset && !marker_we) |=> $stable(marker))
    else $error("marker disturbed by hot reset");

  a_resv_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && rd_sts) |=> (s_axi_rdata & STS_RESV_MASK) == '0)
    else $error("reserved status bits not zero");

  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid && !aw_held && !w_held)
    else $error("write response did not follow the write");
endmodule

// ===== logic/sspb_strap_capture.sv
`timescale 1ns/1ps
module sspb_strap_capture #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic capture,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] held
);
  // pins are expected static after release, so sampling stops there
  always_ff @(posedge aclk)
  begin
    if (capture)
    begin
      held <= pins;
    end
  end

  a_strap_hold: assert property (@(posedge aclk) disable iff (capture)
    !$past(capture) |-> $stable(held))
    else $error("strap value changed outside fundamental reset");
endmodule

// ===== verification/sspb_regs_tb_top.sv
`timescale 1ns/1ps
module sspb_regs_tb_top;
  import sspb_pkg::*;
  logic aclk, aresetn, hot_reset;
  logic [MODE_W-1:0] mode;
  logic ds, us, smb, rck, halt, m01, m23, m45;
  logic [LOCK_W-1:0] lock;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [DATA_W-1:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [STRB_W-1:0] wstrb;
  logic sa, gul, dvul;
  logic [SPEC_W-1:0] spec;
  int n_fail, checked, cyc, i;
  sspb_regs dut (.aclk(aclk), .aresetn(aresetn), .hot_reset(hot_reset),
    .operating_mode_pins(mode), .downstream_common_clock_strap(ds),
    .upstream_common_clock_strap(us), .slow_mgmt_bus_strap(smb), .refclk_mode_strap(rck),
    .reset_halt_strap(halt), .merge_ports_zero_one(m01), .merge_ports_two_three(m23),
    .merge_ports_four_five(m45), .locked_port_state(lock), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .system_allocated_flag(sa), .base_spec_mode(spec),
    .global_register_unlock(gul), .data_value_unlock(dvul));
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic test_done();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      n_fail = n_fail + 1;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // ready is sampled half a cycle early; it only moves after rising edges
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, ha, hw, tb;
    logic [1:0] br;
    ha = 1'b0;
    hw = 1'b0;
    tb = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ha && hw))
    begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      ha = ha | ta;
      hw = hw | tw;
    end
    while (!tb)
    begin
      @(negedge aclk);
      tb = bvalid;
      br = bresp;
      @(posedge aclk);
    end
    bready <= 1'b0;
    // one idle edge so the next call never re-drives bready in this time step
    @(posedge aclk);
    chk("bresp", {30'h0, br}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] rr;
    ta = 1'b0;
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ta)
    begin
      @(negedge aclk);
      ta = arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    while (!tr)
    begin
      @(negedge aclk);
      tr = rvalid;
      d = rdata;
      rr = rresp;
      @(posedge aclk);
    end
    rready <= 1'b0;
    @(posedge aclk);
    chk("rresp", {30'h0, rr}, {30'h0, er});
    chk("rdata", d, ed);
  endtask
  task automatic fund_reset();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  initial
  begin
    n_fail = 0;
    checked = 0;
    cyc = 0;
    aresetn = 1'b0;
    hot_reset = 1'b0;
    mode = MODE_EEPROM;
    lock = 3'h5;
    {ds, us, smb, rck, halt, m01, m23, m45} = 8'ha5;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    fund_reset();
    // straps move after release and must not be followed
    {ds, us, smb, rck, halt, m01, m23, m45} <= 8'h5a;
    lock <= 3'h2;
    rd(STS_OFS, 32'h002054a1, RESP_OKAY);
    wr(CAP_OFS, 32'h1, RESP_OKAY);
    rd(CAP_OFS, 32'h0, RESP_OKAY);
    wr(CTL_OFS, 32'h10, RESP_OKAY);
    rd(CTL_OFS, 32'h0, RESP_OKAY);
    wr(CTL_OFS, 32'h08, RESP_OKAY);
    wr(CAP_OFS, 32'hffffffff, RESP_OKAY);
    rd(CAP_OFS, 32'h1, RESP_OKAY);
    chk("system_allocated_flag", {31'h0, sa}, 32'h1);
    wr(DV_OFS, 32'h1234, RESP_OKAY);
    wr(CTL_OFS, 32'h18, RESP_OKAY);
    chk("data_value_unlock", {31'h0, dvul}, 32'h1);
    rd(DV_OFS, DV_RST, RESP_OKAY);
    for (i = 0; i < DV_COUNT; i++) wr(DV_OFS + 12'(4 * i), 32'ha5000000 | i, RESP_OKAY);
    for (i = 0; i < DV_COUNT; i++) rd(DV_OFS + 12'(4 * i), 32'ha5000000 | i, RESP_OKAY);
    wr(CTL_OFS, 32'h08, RESP_OKAY);
    wr(DV_OFS, 32'h0, RESP_OKAY);
    rd(DV_OFS, 32'ha5000000, RESP_OKAY);
    wr(CTL_OFS, 32'h18, RESP_OKAY);
    rd(DV_OFS, 32'ha5000000, RESP_OKAY);
    wr(STS_OFS, 32'hffffffff, RESP_OKAY);
    rd(STS_OFS, 32'hf0205ca1, RESP_OKAY);
    chk("base_spec_mode", {30'h0, spec}, 32'h3);
    hot_reset <= 1'b1;
    @(posedge aclk);
    hot_reset <= 1'b0;
    rd(CAP_OFS, 32'h0, RESP_OKAY);
    rd(STS_OFS, 32'hf0205ca1, RESP_OKAY);
    rd(CTL_OFS, 32'h18, RESP_OKAY);
    wr(12'h500, 32'hffffffff, RESP_SLVERR);
    rd(12'h500, 32'h0, RESP_SLVERR);
    wr(CTL_OFS, 32'h0, RESP_OKAY);
    wr(STS_OFS, 32'ha0000000, RESP_OKAY);
    rd(STS_OFS, 32'ha0205ca1, RESP_OKAY);
    // top byte lane off: marker must keep its value
    wstrb <= 4'h7;
    wr(STS_OFS, 32'h50000000, RESP_OKAY);
    wstrb <= 4'hf;
    rd(STS_OFS, 32'ha0205ca1, RESP_OKAY);
    // mode pins move only together with the reset assertion
    mode <= MODE_NORMAL;
    fund_reset();
    rd(STS_OFS, 32'h00202740, RESP_OKAY);
    chk("global_register_unlock", {31'h0, gul}, 32'h0);
    test_done();
  end
endmodule
